/* File: rtl/hscan_defs.svh */
// constants for the high-speed can transceiver mode control block
// assumes a 50 MHz system clock and a synchronous active-low reset
//
// Function
// - power-up in off; off always selectable
// - off mode ignores and hides bus wakes
// - normal only in sup normal/init+dev
// - normal mode drives bus from tx input
// - enable delay before first dominant bit
// - early low suppressed; next dominant sent
// - receive modes show bus state on rx
// - receive-only: driver off, reception continues
// - receive-only only in sup normal/stop
// - bias to half supply in normal/rx-only
// - slope bypass bit disables edge shaping
// - mode chosen from written mode field
// - wake-capable mode detects bus wake message
// - field 01 is wake; field kept after wake
// - after wake rx held low until mode change
// - tx dominant timeout: driver off, fault set
`ifndef HSCAN_DEFS_SVH
`define HSCAN_DEFS_SVH

// =========================================================
// mode field encodings
`define HSCAN_FIELD_OFF     2'b00
`define HSCAN_FIELD_WAKE    2'b01
`define HSCAN_FIELD_NORMAL  2'b10
`define HSCAN_FIELD_RXONLY  2'b11

// =========================================================
// timing
`define HSCAN_CLK_MHZ       50
`define HSCAN_T_EN_NS       20000
`define HSCAN_EN_CYC        ((`HSCAN_T_EN_NS * `HSCAN_CLK_MHZ + 999) / 1000)
`define HSCAN_T_TXTO_US     2000
`define HSCAN_TXTO_CYC      (`HSCAN_T_TXTO_US * `HSCAN_CLK_MHZ)
`define HSCAN_T_WAKE_NS     1000
`define HSCAN_WAKE_CYC      ((`HSCAN_T_WAKE_NS * `HSCAN_CLK_MHZ + 999) / 1000)
`define HSCAN_T_WAKE2_US    1000
`define HSCAN_WAKE2_CYC     (`HSCAN_T_WAKE2_US * `HSCAN_CLK_MHZ)

`endif

/* File: rtl/hscan_pkg.sv */
// types shared by the transceiver mode control files
// assumes hscan_defs.svh supplies the numeric constants
package hscan_pkg;
   // =========================================================
   // supervisor modes
   typedef enum logic [2:0] {
      HSCAN_SUP_INIT,
      HSCAN_SUP_NORMAL,
      HSCAN_SUP_STOP,
      HSCAN_SUP_SLEEP,
      HSCAN_SUP_RESTART,
      HSCAN_SUP_FAILSAFE
   } hscan_sup_t;

   // effective transceiver modes
   typedef enum logic [1:0] {
      HSCAN_M_OFF,
      HSCAN_M_WAKE,
      HSCAN_M_NORMAL,
      HSCAN_M_RXONLY
   } hscan_mode_t;

   // analog stage controls
   typedef struct packed {
      logic drv_en;      // bus driver enabled
      logic dominant;    // drive dominant
      logic bias_half;   // bias to half supply
      logic slope_off;   // slope shaping bypass
   } hscan_drv_t;
endpackage : hscan_pkg

/* File: rtl/hscan_wake_det.sv */
// bus wake pattern detector: two dominant phases, short gap
// assumes a synchronised bus level, 1 = dominant
`timescale 1ns/10ps
`include "hscan_defs.svh"
module hscan_wake_det
#(
   parameter int DOM_CYC = `HSCAN_WAKE_CYC,
   parameter int GAP_CYC = `HSCAN_WAKE2_CYC
)
(
   // clock and reset
   input  wire logic i_clk,
   input  wire logic i_rst_n,
   // control
   input  wire logic i_arm,      // detector armed
   input  wire logic i_bus_dom,  // synchronised bus level
   // result
   output logic      o_wake      // one-cycle wake pulse
);
   import hscan_pkg::*;

   // =========================================================
   // counters and phase state
   logic [31:0] cnt_q;        // dominant or gap length
   logic [1:0]  phase_q;      // dominant phases seen

   // count current level length; phases advance on filtered dominant
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n || !i_arm)
      begin
         cnt_q   <= 32'h0000_0000;
         phase_q <= 2'b00;
      end
      else if (i_bus_dom)
      begin
         // first dominant cycle after a gap restarts the length count
         if (cnt_q[31])
            cnt_q <= 32'h0000_0001;
         else
         begin
            // filter: only count once per phase
            if (cnt_q == 32'(DOM_CYC - 1))
               phase_q <= (phase_q == 2'b10) ? 2'b10 : phase_q + 2'b01;
            // saturate below bit 31, which marks a gap count
            if (cnt_q != 32'h7FFF_FFFF)
               cnt_q <= cnt_q + 32'h0000_0001;
         end
      end
      else
      begin
         // a long recessive gap restarts the pattern
         if (cnt_q[31] == 1'b0 && phase_q != 2'b00)
            cnt_q <= 32'h8000_0000;
         else if (cnt_q[31])
         begin
            if (cnt_q[30:0] >= 31'(GAP_CYC))
               phase_q <= 2'b00;
            else
               cnt_q <= cnt_q + 32'h0000_0001;
         end
         else
            cnt_q <= 32'h0000_0000;
      end
   end

   // pulse when second filtered dominant phase completes
   assign o_wake = i_arm && i_bus_dom && phase_q == 2'b01
                   && cnt_q == 32'(DOM_CYC - 1);
endmodule : hscan_wake_det

/* File: rtl/hscan_mode_ctrl.sv */
// top of one high-speed can transceiver channel: mode control,
// enable delay, tx timeout, wake detection, rx output
// assumes tx input and bus level arrive from pins, unsynchronised
`timescale 1ns/10ps
`include "hscan_defs.svh"
module hscan_mode_ctrl
#(
   parameter int EN_CYC   = `HSCAN_EN_CYC,
   parameter int TXTO_CYC = `HSCAN_TXTO_CYC,
   parameter int WAKE_CYC = `HSCAN_WAKE_CYC,
   parameter int GAP_CYC  = `HSCAN_WAKE2_CYC
)
(
   // clock and reset
   input  wire logic              i_clk,
   input  wire logic              i_rst_n,
   // software control
   input  wire logic [1:0]        i_channel_mode_field,
   input  wire logic              i_field_we,
   input  wire logic              i_slope_bypass,
   input  wire logic              i_dev_mode,
   input  wire hscan_pkg::hscan_sup_t i_sup_mode,
   // controller side pins
   input  wire logic              i_tx_data_in,
   output logic                   o_rx_data_out,
   // bus side
   input  wire logic              i_bus_dom,
   output hscan_pkg::hscan_drv_t  o_drv,
   // status
   output logic [1:0]             o_channel_mode_field,
   output hscan_pkg::hscan_mode_t o_mode,
   output logic                   o_wake_flag,
   output logic                   o_fail_flag,
   input  wire logic              i_fail_clr
);
   import hscan_pkg::*;

   // =========================================================
   // pin synchronisers
   logic [1:0] tx_sync_q;    // tx input, bit 1 usable
   logic [1:0] bus_sync_q;   // bus level, bit 1 usable
   logic       tx_s;
   logic       bus_s;

   // two flops for each asynchronous pin
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         tx_sync_q  <= 2'b11;
         bus_sync_q <= 2'b00;
      end
      else
      begin
         tx_sync_q  <= {tx_sync_q[0], i_tx_data_in};
         bus_sync_q <= {bus_sync_q[0], i_bus_dom};
      end
   end
   assign tx_s  = tx_sync_q[1];
   assign bus_s = bus_sync_q[1];

   // =========================================================
   // mode field storage
   logic [1:0]  field_q;     // software mode field
   hscan_mode_t mode_d;      // effective mode after gating
   hscan_mode_t mode_q;

   // field holds value even after a wake, only software writes it
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
         field_q <= `HSCAN_FIELD_OFF;
      else if (i_field_we)
         field_q <= i_channel_mode_field;
   end
   assign o_channel_mode_field = field_q;

   // =========================================================
   // supervisor gating; fallback keeps the channel listening
   // where possible so a wake is never silently missed
   always_comb
   begin
      mode_d = HSCAN_M_OFF;
      case (field_q)
         `HSCAN_FIELD_OFF:
            mode_d = HSCAN_M_OFF;
         `HSCAN_FIELD_WAKE:
            mode_d = HSCAN_M_WAKE;
         `HSCAN_FIELD_NORMAL:
         begin
            if (i_sup_mode == HSCAN_SUP_NORMAL ||
                (i_sup_mode == HSCAN_SUP_INIT && i_dev_mode))
               mode_d = HSCAN_M_NORMAL;
            else if (i_sup_mode == HSCAN_SUP_STOP)
               mode_d = HSCAN_M_RXONLY;
            else
               mode_d = HSCAN_M_WAKE;
         end
         default:
         begin
            if (i_sup_mode == HSCAN_SUP_NORMAL ||
                i_sup_mode == HSCAN_SUP_STOP)
               mode_d = HSCAN_M_RXONLY;
            else
               mode_d = HSCAN_M_WAKE;
         end
      endcase
   end

   // register the effective mode
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
         mode_q <= HSCAN_M_OFF;
      else
         mode_q <= mode_d;
   end
   assign o_mode = mode_q;

   // =========================================================
   // enable delay counter
   logic [31:0] en_cnt_q;    // cycles since normal entry
   logic        en_done;     // delay elapsed
   logic        armed_q;     // recessive seen after delay

   // restart on every entry into normal mode
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n || mode_q != HSCAN_M_NORMAL)
         en_cnt_q <= 32'h0000_0000;
      else if (!en_done)
         en_cnt_q <= en_cnt_q + 32'h0000_0001;
   end
   assign en_done = (en_cnt_q >= 32'(EN_CYC));

   // a low held over the delay end is suppressed until it rises
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n || mode_q != HSCAN_M_NORMAL)
         armed_q <= 1'b0;
      else if (en_done && tx_s)
         armed_q <= 1'b1;
   end

   // =========================================================
   // tx dominant timeout
   logic [31:0] to_cnt_q;    // dominant length
   logic        to_act_q;    // timeout active, driver off
   logic        fail_q;      // sticky fault flag

   // count dominant tx; release when tx goes recessive again
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n || mode_q != HSCAN_M_NORMAL || tx_s)
      begin
         to_cnt_q <= 32'h0000_0000;
         to_act_q <= 1'b0;
      end
      else if (armed_q)
      begin
         if (to_cnt_q >= 32'(TXTO_CYC))
            to_act_q <= 1'b1;
         else
            to_cnt_q <= to_cnt_q + 32'h0000_0001;
      end
   end

   // set wins over clear
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
         fail_q <= 1'b0;
      else if (to_act_q)
         fail_q <= 1'b1;
      else if (i_fail_clr)
         fail_q <= 1'b0;
   end
   assign o_fail_flag = fail_q;

   // =========================================================
   // wake detection
   logic wake_pulse;         // detector output
   logic wake_q;             // woken, rx held low
   logic wake_flag_q;        // sticky wake report

   hscan_wake_det #(
      .DOM_CYC (WAKE_CYC),
      .GAP_CYC (GAP_CYC)
   ) u_wake (
      .i_clk     (i_clk),
      .i_rst_n   (i_rst_n),
      .i_arm     (mode_q == HSCAN_M_WAKE && !wake_q),
      .i_bus_dom (bus_s),
      .o_wake    (wake_pulse)
   );

   // woken state lasts until the mode changes; off never reports
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n || mode_q != HSCAN_M_WAKE)
         wake_q <= 1'b0;
      else if (wake_pulse)
         wake_q <= 1'b1;
   end

   // report flag; set wins over clear
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
         wake_flag_q <= 1'b0;
      else if (wake_pulse)
         wake_flag_q <= 1'b1;
      else if (i_field_we)
         wake_flag_q <= 1'b0;
   end
   assign o_wake_flag = wake_flag_q;

   // =========================================================
   // outputs to bus stage and controller
   hscan_drv_t drv_q;
   logic       rx_q;

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         drv_q <= '0;
         rx_q  <= 1'b1;
      end
      else
      begin
         // driver only in normal mode and outside timeout
         drv_q.drv_en    <= mode_q == HSCAN_M_NORMAL
                            && !to_act_q;
         drv_q.dominant  <= mode_q == HSCAN_M_NORMAL && armed_q
                            && !to_act_q && !tx_s;
         drv_q.bias_half <= mode_q == HSCAN_M_NORMAL
                            || mode_q == HSCAN_M_RXONLY;
         drv_q.slope_off <= i_slope_bypass;
         // rx shows bus in receive modes, low once woken
         if (mode_q == HSCAN_M_WAKE && (wake_q || wake_pulse))
            rx_q <= 1'b0;
         else if (mode_q == HSCAN_M_NORMAL
                  || mode_q == HSCAN_M_RXONLY)
            rx_q <= !bus_s;
         else
            rx_q <= 1'b1;
      end
   end
   assign o_drv         = drv_q;
   assign o_rx_data_out = rx_q;

   // =========================================================
   // assertions
   property p_off_reset;
      @(posedge i_clk) !i_rst_n |=> mode_q == HSCAN_M_OFF;
   endproperty
   a_off_reset: assert property (p_off_reset)
      else $error("mode not off after reset");

   property p_off_no_wake;
      @(posedge i_clk) disable iff (!i_rst_n)
      mode_q == HSCAN_M_OFF |-> !wake_pulse ##1 o_rx_data_out;
   endproperty
   a_off_no_wake: assert property (p_off_no_wake)
      else $error("wake seen in off mode");

   property p_normal_gate;
      @(posedge i_clk) disable iff (!i_rst_n)
      mode_q == HSCAN_M_NORMAL |-> $past(i_sup_mode)
         == HSCAN_SUP_NORMAL || ($past(i_sup_mode) == HSCAN_SUP_INIT
         && $past(i_dev_mode));
   endproperty
   a_normal_gate: assert property (p_normal_gate)
      else $error("normal mode in wrong supervisor mode");

   property p_no_early_dom;
      @(posedge i_clk) disable iff (!i_rst_n)
      mode_q == HSCAN_M_NORMAL && !en_done |=> !o_drv.dominant;
   endproperty
   a_no_early_dom: assert property (p_no_early_dom)
      else $error("dominant during enable delay");

   property p_rxonly_no_drv;
      @(posedge i_clk) disable iff (!i_rst_n)
      mode_q == HSCAN_M_RXONLY |=> !o_drv.drv_en && o_drv.bias_half;
   endproperty
   a_rxonly_no_drv: assert property (p_rxonly_no_drv)
      else $error("driver on in receive-only mode");

   property p_rx_follow;
      @(posedge i_clk) disable iff (!i_rst_n)
      mode_q == HSCAN_M_RXONLY |=> o_rx_data_out == !$past(bus_s);
   endproperty
   a_rx_follow: assert property (p_rx_follow)
      else $error("rx does not follow bus");

   property p_wake_hold;
      @(posedge i_clk) disable iff (!i_rst_n)
      wake_q && mode_q == HSCAN_M_WAKE |=> !o_rx_data_out;
   endproperty
   a_wake_hold: assert property (p_wake_hold)
      else $error("rx released while woken");

   property p_timeout_fail;
      @(posedge i_clk) disable iff (!i_rst_n)
      to_act_q |=> o_fail_flag && !o_drv.drv_en;
   endproperty
   a_timeout_fail: assert property (p_timeout_fail)
      else $error("timeout did not disable driver");

   c_normal_tx: cover property (@(posedge i_clk) o_drv.dominant);
   c_wake: cover property (@(posedge i_clk) wake_pulse);
   c_timeout: cover property (@(posedge i_clk) to_act_q);
endmodule : hscan_mode_ctrl

/* File: dv/hscan_ctrl_model.sv */
// can controller stand-in: one dominant burst per request on tx
// assumes the bench pulses i_go on a falling edge, tx idles high
`timescale 1ns/10ps
module hscan_ctrl_model
#(
   parameter int WAIT_CYC = 12   // idle-high span over enable delay
)
(
   // clock
   input  wire logic       i_clk,
   // request
   input  wire logic       i_go,     // start one burst
   input  wire logic       i_early,  // misbehave: low inside delay
   input  wire logic [7:0] i_len,    // dominant cycles
   // pins
   output logic            o_tx,     // drives tx_data_in
   output logic            o_busy    // burst in progress
);
   int         cnt = 0;      // cycles since start
   logic       early_q = 0;  // latched misbehave request
   logic [7:0] len_q = 0;    // latched burst length
   initial o_busy = 1'b0;
   // =========================================================
   // sequencer on the rising edge; nonblocking updates keep tx
   // changes after the design has sampled, and i_go is stable here
   always @(posedge i_clk)
   begin
      if (i_go)
      begin
         early_q <= i_early;
         len_q   <= i_len;
         cnt     <= 0;
         o_busy  <= 1'b1;
      end
      else if (o_busy)
      begin
         cnt    <= cnt + 1;
         o_busy <= (cnt < WAIT_CYC + len_q);
      end
   end
   // tx held high until the delay is over; early low only on request
   always_comb o_tx = !(o_busy && ((early_q && cnt < 3) ||
      (cnt >= WAIT_CYC && cnt < WAIT_CYC + len_q)));
endmodule : hscan_ctrl_model

/* File: dv/testbench.sv */
// self-checking bench for the transceiver mode control channel
// assumes shortened counts: delay 8, timeout 20, wake 3/20
`timescale 1ns/10ps
module testbench import hscan_pkg::*;;
   logic        clk, rst_n, we, slope, dev, fclr, bus_x, go, early;
   logic [1:0]  fld, fld_o;
   logic [7:0]  len;
   logic        tx, busy, rx, wk, fl;
   hscan_sup_t  sup;
   hscan_drv_t  drv;
   hscan_mode_t mode;
   int          fail_count = 0;
   int          comparisons = 0;
   int          dom_cnt = 0;  // cycles driven dominant
   int          rx_cnt = 0;   // cycles rx low
   // loopback: our driver plus bench-made traffic
   wire bus = (drv.drv_en & drv.dominant) | bus_x;
   hscan_mode_ctrl #(.EN_CYC(8), .TXTO_CYC(20), .WAKE_CYC(3),
      .GAP_CYC(20)) i_dut (.i_clk(clk), .i_rst_n(rst_n),
      .i_channel_mode_field(fld), .i_field_we(we),
      .i_slope_bypass(slope), .i_dev_mode(dev), .i_sup_mode(sup),
      .i_tx_data_in(tx), .o_rx_data_out(rx), .i_bus_dom(bus),
      .o_drv(drv), .o_channel_mode_field(fld_o), .o_mode(mode),
      .o_wake_flag(wk), .o_fail_flag(fl), .i_fail_clr(fclr));
   hscan_ctrl_model i_ctrl (.i_clk(clk), .i_go(go), .i_early(early),
      .i_len(len), .o_tx(tx), .o_busy(busy));
   // =========================================================
   // clock, counters, watchdog
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk)
   begin
      if ((drv.drv_en & drv.dominant) === 1'b1) dom_cnt++;
      if (rx === 1'b0) rx_cnt++;
   end
   initial
   begin
      #100000;
      fail_count++;
      stop_test();
   end
   // =========================================================
   // helpers
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask : cyc
   task automatic chk_bit(input logic a, input logic e);
      comparisons++;
      if (a !== e)
      begin
         fail_count++;
         $display("ERROR %0t bit %b exp %b", $time, a, e);
      end
   endtask : chk_bit
   task automatic chk_vec(input logic [1:0] a, input logic [1:0] e);
      comparisons++;
      if (a !== e)
      begin
         fail_count++;
         $display("ERROR %0t vec %b exp %b", $time, a, e);
      end
   endtask : chk_vec
   task automatic chk_num(input int a, input int e);
      comparisons++;
      if (a != e)
      begin
         fail_count++;
         $display("ERROR %0t count %0d exp %0d", $time, a, e);
      end
   endtask : chk_num
   task automatic stop_test();
      if (fail_count == 0 && comparisons > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : stop_test
   // one write pulse; mode settles two edges later
   task automatic wr(input logic [1:0] v);
      fld = v;
      we  = 1'b1;
      cyc(1);
      we  = 1'b0;
      cyc(3);
   endtask : wr
   // burst from the controller, then let the pipeline drain
   task automatic send(input logic e, input logic [7:0] n);
      dom_cnt = 0;
      rx_cnt  = 0;
      early   = e;
      len     = n;
      go      = 1'b1;
      cyc(1);
      go      = 1'b0;
      for (int i = 0; i < 100 && busy; i++) cyc(1);
      cyc(6);
   endtask : send
   // two long dominant phases split by a short recessive gap
   task automatic wake_pat();
      bus_x = 1'b1;
      cyc(6);
      bus_x = 1'b0;
      cyc(5);
      bus_x = 1'b1;
      cyc(6);
      bus_x = 1'b0;
      cyc(6);
   endtask : wake_pat
   function automatic hscan_mode_t exp_mode(hscan_sup_t s, logic d,
                                            logic n);
      if (n && (s == HSCAN_SUP_NORMAL || (s == HSCAN_SUP_INIT && d)))
         return HSCAN_M_NORMAL;
      if (s == HSCAN_SUP_NORMAL || s == HSCAN_SUP_STOP)
         return HSCAN_M_RXONLY;
      return HSCAN_M_WAKE;
   endfunction : exp_mode
   // =========================================================
   // scenarios
   task automatic t_reset();
      chk_vec(mode, HSCAN_M_OFF);
      chk_vec(fld_o, 2'b00);
      chk_bit(|drv, 1'b0);
      chk_bit(rx & !wk & !fl, 1'b1);
   endtask : t_reset
   task automatic t_off();
      sup = HSCAN_SUP_NORMAL;
      wr(2'b00);
      wake_pat();
      chk_bit(wk, 1'b0);
      chk_bit(rx, 1'b1);
   endtask : t_off
   task automatic t_grant();
      for (int s = 0; s < 6; s++)
         for (int d = 0; d < 2; d++)
         begin
            sup = hscan_sup_t'(s);
            dev = d[0];
            wr(2'b10);
            chk_vec(mode, exp_mode(sup, dev, 1'b1));
            wr(2'b11);
            chk_vec(mode, exp_mode(sup, dev, 1'b0));
            wr(2'b00);
            chk_vec(mode, HSCAN_M_OFF);
            wr(2'b01);
            chk_vec(mode, HSCAN_M_WAKE);
         end
      dev = 1'b0;
      wr(2'b00);
   endtask : t_grant
   task automatic t_normal();
      sup   = HSCAN_SUP_NORMAL;
      slope = 1'b1;
      wr(2'b10);
      chk_bit(drv.drv_en, 1'b1);
      chk_bit(drv.bias_half, 1'b1);
      chk_bit(drv.slope_off, 1'b1);
      send(1'b1, 8'd5);
      chk_num(dom_cnt, 5);
      chk_num(rx_cnt, 5);
      send(1'b0, 8'd4);
      chk_num(dom_cnt, 4);
      slope = 1'b0;
      cyc(4);
      chk_bit(drv.slope_off, 1'b0);
   endtask : t_normal
   task automatic t_timeout();
      len = 8'd30;
      go  = 1'b1;
      cyc(1);
      go  = 1'b0;
      cyc(39);
      chk_bit(drv.drv_en, 1'b0);
      chk_bit(fl, 1'b1);
      for (int i = 0; i < 100 && busy; i++) cyc(1);
      cyc(6);
      chk_bit(drv.drv_en, 1'b1);
      fclr = 1'b1;
      cyc(1);
      fclr = 1'b0;
      cyc(2);
      chk_bit(fl, 1'b0);
   endtask : t_timeout
   task automatic t_rxonly();
      wr(2'b11);
      chk_bit(drv.drv_en, 1'b0);
      chk_bit(drv.bias_half, 1'b1);
      send(1'b0, 8'd5);
      chk_num(dom_cnt, 0);
      bus_x = 1'b1;
      cyc(4);
      chk_bit(rx, 1'b0);
      bus_x = 1'b0;
      cyc(4);
      chk_bit(rx, 1'b1);
      // re-entry into normal must restart the delay: early low dropped
      wr(2'b10);
      send(1'b1, 8'd5);
      chk_num(dom_cnt, 5);
   endtask : t_rxonly
   task automatic t_wake();
      sup = HSCAN_SUP_STOP;
      wr(2'b01);
      chk_bit(rx, 1'b1);
      wake_pat();
      chk_bit(wk, 1'b1);
      chk_vec(fld_o, 2'b01);
      cyc(30);
      chk_bit(rx, 1'b0);
      wr(2'b11);
      cyc(2);
      chk_bit(rx, 1'b1);
      chk_bit(wk, 1'b0);
   endtask : t_wake
   // =========================================================
   // main sequence
   initial
   begin
      {rst_n, we, slope, dev, fclr, bus_x, go, early} = '0;
      fld = 2'b00;
      len = 8'd0;
      sup = HSCAN_SUP_INIT;
      repeat (8) @(negedge clk);
      rst_n = 1'b1;
      cyc(1);
      t_reset();
      t_off();
      t_grant();
      t_normal();
      t_timeout();
      t_rxonly();
      t_wake();
      rst_n = 1'b0;
      cyc(2);
      rst_n = 1'b1;
      cyc(1);
      t_reset();
      stop_test();
   end
endmodule : testbench
